// >>> adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Register byte offsets
`define ADC_CTRL_OFS        12'h000
`define ADC_STATUS_OFS      12'h004
`define ADC_FORCE_OFS       12'h008
`define ADC_PREMUX_OFS      12'h00c
`define ADC_EDGE_LO_OFS     12'h010
`define ADC_EDGE_HI_OFS     12'h014
`define ADC_PRIO_OFS        12'h018
`define ADC_TRIG_CFG_BASE   12'h100
`define ADC_SLOT_CFG_BASE   12'h200
`define ADC_RESULT_BASE     12'h300

// Control register fields
`define CTRL_PD_BIT         0
`define CTRL_ENH_BIT        1
`define CTRL_REPEAT_BIT     2
`define CTRL_START_BIT      3
`define CTRL_IRQ_EN_BIT     4
`define CTRL_LINE_LSB       5
`define CTRL_CHAN_LSB       8
`define CTRL_WIDTH          12
`define CTRL_RESET          12'h001

// Status register fields
`define STAT_BUSY_BIT       0
`define STAT_MANUAL_BIT     1
`define STAT_SLOT_LSB       8
`define STAT_TRIG_LSB       16

// Premux register fields
`define PMX_SEL_LSB         0
`define PMX_HOLD_BIT        8
`define PMX_WIDTH           9
`define PMX_RESET           9'h000

// Trigger chain fields
`define TCFG_FIRST_LSB      0
`define TCFG_LEN_LSB        5
`define TCFG_REPEAT_BIT     10
`define TCFG_END_IRQ_BIT    11
`define TCFG_LINE_LSB       12
`define TCFG_WIDTH          14
`define TCFG_RESET          14'h0000

// Slot fields
`define SCFG_CHAN_LSB       0
`define SCFG_SEL_LSB        4
`define SCFG_IRQ_EN_BIT     12
`define SCFG_LINE_LSB       13
`define SCFG_WIDTH          15
`define SCFG_RESET          15'h0000

// Priority register: 3 bits per request line
`define PRIO_WIDTH          12
`define PRIO_RESET          12'h000

// Result width and reset
`define RESULT_WIDTH        12
`define RESULT_RESET        12'h000

// Conversion timing
`define CLK_PERIOD_NS       25
`define CONV_STD_NS         400
`define CONV_ENH_NS         500
`define SAMPLE_HOLD_NS      75
`define CONV_STD_CYCLES     (`CONV_STD_NS / `CLK_PERIOD_NS)
`define CONV_ENH_CYCLES     (`CONV_ENH_NS / `CLK_PERIOD_NS)
`define SAMPLE_CYCLES       (`SAMPLE_HOLD_NS / `CLK_PERIOD_NS)

`endif

// >>> adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [1:0] {
    EDGE_OFF,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_t;

endpackage

// >>> adc_trigger_sequencer.sv
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module adc_trigger_sequencer #(
  parameter int NUM_TRIG  = 32,
  parameter int NUM_SLOTS = 24
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic [NUM_TRIG-1:0]  trig_i,
  input  wire logic [11:0]          conv_data_i,
  output logic                      conv_power_down_o,
  output logic                      conv_sample_o,
  output logic                      conv_start_o,
  output logic      [3:0]           conv_channel_o,
  output logic      [7:0]           premux_sel_o,
  output logic                      fe_hold_o,
  output logic      [3:0]           irq_o,
  output logic      [11:0]          irq_prio_o,
  output logic                      busy_o
);

  localparam logic [4:0] STD_LAST = 5'(`CONV_STD_CYCLES - 1);
  localparam logic [4:0] ENH_LAST = 5'(`CONV_ENH_CYCLES - 1);
  localparam logic [4:0] SMP_LAST = 5'(`SAMPLE_CYCLES - 1);

  // Parameter sanity
  if (NUM_TRIG < 1 || NUM_TRIG > 32 || NUM_SLOTS < 1 || NUM_SLOTS > 24) begin : g_chk
    $error("adc_trigger_sequencer: unsupported trigger or slot count");
  end

  // Phase counter is five bits; sampling must end before the conversion does
  if (`SAMPLE_CYCLES < 1 || `SAMPLE_CYCLES >= `CONV_STD_CYCLES ||
      `CONV_ENH_CYCLES > 32) begin : g_chk_time
    $error("adc_trigger_sequencer: conversion timing does not fit the counter");
  end

  // Decode of an indexed register bank
  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base,
                                   input int unsigned n);
    return (a[11:8] == base[11:8]) && (a[1:0] == 2'b00) && (int'(a[7:2]) < n);
  endfunction

  // First slot of a chain; a field beyond the slot bank starts at slot zero
  function automatic logic [4:0] chain_first(input logic [`TCFG_WIDTH-1:0] c);
    logic [4:0] f;
    f = c[`TCFG_FIRST_LSB +: 5];
    return (int'(f) < NUM_SLOTS) ? f : 5'd0;
  endfunction

  logic [`CTRL_WIDTH-1:0]    ctrl;
  logic [`PMX_WIDTH-1:0]     premux_reg;
  logic [63:0]               edge_cfg;
  logic [`PRIO_WIDTH-1:0]    prio;
  logic [`TCFG_WIDTH-1:0]    tcfg [NUM_TRIG];
  logic [`SCFG_WIDTH-1:0]    scfg [NUM_SLOTS];
  logic [`RESULT_WIDTH-1:0]  result [NUM_SLOTS];
  logic [NUM_TRIG-1:0]       trig_prev;
  logic [NUM_TRIG-1:0]       pending;
  logic [NUM_TRIG-1:0]       trig_hit;
  logic [NUM_TRIG-1:0]       force_vec;
  adc_seq_pkg::conv_state_t  state;
  logic [4:0]                cnt;
  logic [4:0]                slot;
  logic [4:0]                remain;
  logic [4:0]                cur_trig;
  logic                      manual;
  logic                      manual_go;
  logic                      wr_acc;
  logic                      setup;
  logic                      last_cycle;
  logic                      conv_done;
  logic                      enh_run;
  logic [4:0]                next_trig;
  logic                      next_found;
  logic [`SCFG_WIDTH-1:0]    cur_scfg;
  logic [`TCFG_WIDTH-1:0]    cur_tcfg;
  logic [`TCFG_WIDTH-1:0]    nxt_tcfg;

  assign wr_acc   = psel_i && penable_i && pwrite_i;
  assign setup    = psel_i && !penable_i;
  assign pready_o = 1'b1;
  assign busy_o   = (state != adc_seq_pkg::ST_IDLE);
  assign conv_power_down_o = ctrl[`CTRL_PD_BIT];
  assign irq_prio_o = prio;

  // Control register; start bit self-clears when the conversion is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_acc && paddr_i == `ADC_CTRL_OFS) begin
      ctrl <= pwdata_i[`CTRL_WIDTH-1:0];
    end else if (state == adc_seq_pkg::ST_IDLE && manual_go && pending == '0) begin
      ctrl[`CTRL_START_BIT] <= 1'b0;
    end
  end

  assign manual_go = ctrl[`CTRL_START_BIT] && !ctrl[`CTRL_PD_BIT];

  // Plain configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      premux_reg <= `PMX_RESET;
      edge_cfg   <= '0;
      prio       <= `PRIO_RESET;
    end else if (wr_acc) begin
      if (paddr_i == `ADC_PREMUX_OFS) premux_reg <= pwdata_i[`PMX_WIDTH-1:0];
      if (paddr_i == `ADC_EDGE_LO_OFS) edge_cfg[31:0] <= pwdata_i;
      if (paddr_i == `ADC_EDGE_HI_OFS) edge_cfg[63:32] <= pwdata_i;
      if (paddr_i == `ADC_PRIO_OFS) prio <= pwdata_i[`PRIO_WIDTH-1:0];
    end
  end

  // Trigger chain and slot configuration banks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_TRIG; i++) tcfg[i] <= `TCFG_RESET;
      for (int i = 0; i < NUM_SLOTS; i++) scfg[i] <= `SCFG_RESET;
    end else if (wr_acc) begin
      if (in_bank(paddr_i, `ADC_TRIG_CFG_BASE, NUM_TRIG)) begin
        tcfg[paddr_i[6:2]] <= pwdata_i[`TCFG_WIDTH-1:0];
      end
      if (in_bank(paddr_i, `ADC_SLOT_CFG_BASE, NUM_SLOTS)) begin
        scfg[paddr_i[6:2]] <= pwdata_i[`SCFG_WIDTH-1:0];
      end
    end
  end

  // Edge detection per trigger input
  genvar g;
  generate
    for (g = 0; g < NUM_TRIG; g++) begin : g_trig
      logic rise;
      logic fall;
      adc_seq_pkg::edge_sel_t mode;
      assign mode = adc_seq_pkg::edge_sel_t'(edge_cfg[2*g +: 2]);
      assign rise = trig_i[g] && !trig_prev[g];
      assign fall = !trig_i[g] && trig_prev[g];
      assign trig_hit[g] = (rise && (mode == adc_seq_pkg::EDGE_RISE ||
                                     mode == adc_seq_pkg::EDGE_BOTH)) ||
                           (fall && (mode == adc_seq_pkg::EDGE_FALL ||
                                     mode == adc_seq_pkg::EDGE_BOTH));
      assign force_vec[g] = wr_acc && paddr_i == `ADC_FORCE_OFS &&
                            pwdata_i[4:0] == 5'(g);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev <= '0;
    end else begin
      trig_prev <= trig_i;
    end
  end

  // Pending requests are only collected while idle; taken one is cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= '0;
    end else if (state == adc_seq_pkg::ST_IDLE && !ctrl[`CTRL_PD_BIT]) begin
      pending <= (pending | trig_hit | force_vec) &
                 ~(next_found ? (NUM_TRIG'(1) << next_trig) : '0);
    end else begin
      pending <= '0;
    end
  end

  // Lowest numbered pending trigger wins
  always_comb begin
    next_trig  = '0;
    next_found = 1'b0;
    for (int i = NUM_TRIG - 1; i >= 0; i--) begin
      if (pending[i]) begin
        next_trig  = 5'(i);
        next_found = 1'b1;
      end
    end
  end

  assign cur_scfg   = scfg[slot];
  assign cur_tcfg   = tcfg[cur_trig];
  assign nxt_tcfg   = tcfg[next_trig];
  assign last_cycle = (cnt == (enh_run ? ENH_LAST : STD_LAST));
  assign conv_done  = (state == adc_seq_pkg::ST_CONVERT) && last_cycle;

  // Conversion length is fixed while a conversion runs; a mid-run write waits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enh_run <= 1'b0;
    end else if (state == adc_seq_pkg::ST_IDLE || conv_done) begin
      enh_run <= ctrl[`CTRL_ENH_BIT];
    end
  end

  // Conversion and sequencing state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= adc_seq_pkg::ST_IDLE;
      cnt      <= '0;
      slot     <= '0;
      remain   <= '0;
      cur_trig <= '0;
      manual   <= 1'b0;
    end else begin
      unique case (state)
        adc_seq_pkg::ST_IDLE: begin
          cnt <= '0;
          if (ctrl[`CTRL_PD_BIT]) begin
            state <= adc_seq_pkg::ST_IDLE;
          end else if (next_found) begin
            state    <= adc_seq_pkg::ST_SAMPLE;
            cur_trig <= next_trig;
            slot     <= chain_first(nxt_tcfg);
            remain   <= nxt_tcfg[`TCFG_LEN_LSB +: 5];
            manual   <= 1'b0;
          end else if (manual_go) begin
            state  <= adc_seq_pkg::ST_SAMPLE;
            manual <= 1'b1;
          end
        end
        adc_seq_pkg::ST_SAMPLE: begin
          cnt <= cnt + 5'd1;
          if (cnt == SMP_LAST) state <= adc_seq_pkg::ST_CONVERT;
        end
        adc_seq_pkg::ST_CONVERT: begin
          cnt <= cnt + 5'd1;
          if (last_cycle) begin
            cnt <= '0;
            if (ctrl[`CTRL_PD_BIT]) begin
              state <= adc_seq_pkg::ST_IDLE;
            end else if (manual) begin
              state <= ctrl[`CTRL_REPEAT_BIT] ? adc_seq_pkg::ST_SAMPLE
                                              : adc_seq_pkg::ST_IDLE;
            end else if (remain != 5'd0) begin
              state  <= adc_seq_pkg::ST_SAMPLE;
              remain <= remain - 5'd1;
              slot   <= (slot == 5'(NUM_SLOTS - 1)) ? 5'd0 : slot + 5'd1;
            end else if (cur_tcfg[`TCFG_REPEAT_BIT]) begin
              state  <= adc_seq_pkg::ST_SAMPLE;
              slot   <= chain_first(cur_tcfg);
              remain <= cur_tcfg[`TCFG_LEN_LSB +: 5];
            end else begin
              state <= adc_seq_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Pseudo-DMA copy into the owning slot's result register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) result[i] <= `RESULT_RESET;
    end else if (conv_done && !manual) begin
      result[slot] <= conv_data_i;
    end
  end

  // Manual result kept apart from the slot storage
  logic [`RESULT_WIDTH-1:0] manual_result;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      manual_result <= `RESULT_RESET;
    end else if (conv_done && manual) begin
      manual_result <= conv_data_i;
    end
  end

  // Interrupt pulses on the selected request line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= '0;
    end else begin
      irq_o <= '0;
      if (conv_done && manual && ctrl[`CTRL_IRQ_EN_BIT]) begin
        irq_o[ctrl[`CTRL_LINE_LSB +: 2]] <= 1'b1;
      end
      if (conv_done && !manual && cur_scfg[`SCFG_IRQ_EN_BIT]) begin
        irq_o[cur_scfg[`SCFG_LINE_LSB +: 2]] <= 1'b1;
      end
      if (conv_done && !manual && remain == 5'd0 && cur_tcfg[`TCFG_END_IRQ_BIT]) begin
        irq_o[cur_tcfg[`TCFG_LINE_LSB +: 2]] <= 1'b1;
      end
    end
  end

  // Converter strobes: sample level, then a start pulse as the phase closes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_sample_o <= 1'b0;
      conv_start_o  <= 1'b0;
    end else begin
      conv_sample_o <= (state == adc_seq_pkg::ST_SAMPLE) && (cnt != SMP_LAST);
      conv_start_o  <= (state == adc_seq_pkg::ST_SAMPLE) && (cnt == SMP_LAST);
    end
  end

  // Channel, premux select and hold toward the front end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_channel_o <= '0;
      premux_sel_o   <= '0;
      fe_hold_o      <= 1'b0;
    end else if (busy_o && !manual) begin
      conv_channel_o <= cur_scfg[`SCFG_CHAN_LSB +: 4];
      premux_sel_o   <= cur_scfg[`SCFG_SEL_LSB +: 8];
      fe_hold_o      <= (state == adc_seq_pkg::ST_CONVERT) && !last_cycle;
    end else begin
      conv_channel_o <= ctrl[`CTRL_CHAN_LSB +: 4];
      premux_sel_o   <= premux_reg[`PMX_SEL_LSB +: 8];
      fe_hold_o      <= premux_reg[`PMX_HOLD_BIT] ||
                        ((state == adc_seq_pkg::ST_CONVERT) && !last_cycle);
    end
  end

  // Read data and error answer, captured in the setup phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
      if (paddr_i == `ADC_CTRL_OFS) begin
        prdata_o[`CTRL_WIDTH-1:0] <= ctrl;
      end else if (paddr_i == `ADC_STATUS_OFS) begin
        prdata_o[`STAT_BUSY_BIT]          <= busy_o;
        prdata_o[`STAT_MANUAL_BIT]        <= manual;
        prdata_o[`STAT_SLOT_LSB +: 5]     <= slot;
        prdata_o[`STAT_TRIG_LSB +: 5]     <= cur_trig;
        prdata_o[31:20]                   <= manual_result;
      end else if (paddr_i == `ADC_FORCE_OFS) begin
        prdata_o <= '0;
      end else if (paddr_i == `ADC_PREMUX_OFS) begin
        prdata_o[`PMX_WIDTH-1:0] <= premux_reg;
      end else if (paddr_i == `ADC_EDGE_LO_OFS) begin
        prdata_o <= edge_cfg[31:0];
      end else if (paddr_i == `ADC_EDGE_HI_OFS) begin
        prdata_o <= edge_cfg[63:32];
      end else if (paddr_i == `ADC_PRIO_OFS) begin
        prdata_o[`PRIO_WIDTH-1:0] <= prio;
      end else if (in_bank(paddr_i, `ADC_TRIG_CFG_BASE, NUM_TRIG)) begin
        prdata_o[`TCFG_WIDTH-1:0] <= tcfg[paddr_i[6:2]];
      end else if (in_bank(paddr_i, `ADC_SLOT_CFG_BASE, NUM_SLOTS)) begin
        prdata_o[`SCFG_WIDTH-1:0] <= scfg[paddr_i[6:2]];
      end else if (in_bank(paddr_i, `ADC_RESULT_BASE, NUM_SLOTS)) begin
        prdata_o[`RESULT_WIDTH-1:0] <= result[paddr_i[6:2]];
      end else begin
        pslverr_o <= 1'b1;
      end
    end
  end

endmodule

// >>> afe_model.sv
`timescale 1ns/10ps
module afe_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  channel_i,
  input  wire logic [7:0]  sel_i,
  output logic      [11:0] data_o
);
  int left;

  // Hold the level taken at start through the conversion, then let the line wander
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 12'h000;
      left   <= 0;
    end else if (start_i) begin
      data_o <= {sel_i, channel_i};
      left   <= 17;
    end else if (left != 0) begin
      left <= left - 1;
    end else begin
      data_o <= ~data_o; // Released: no stale value
    end
  end
endmodule

// >>> adc_seq_checker_sva.sv
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module adc_seq_checker #(
  parameter int NUM_TRIG  = 32,
  parameter int NUM_SLOTS = 24
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        conv_power_down_o,
  input wire logic        conv_start_o,
  input wire logic [7:0]  premux_sel_o,
  input wire logic [3:0]  irq_o,
  input wire logic [11:0] irq_prio_o,
  input wire logic        busy_o
);
  wire logic wr_ok = psel_i && penable_i && pwrite_i;
  logic      enh;
  int        run;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Follow the enhanced-mode bit as software writes it
  always_ff @(posedge clk_i) begin
    if (rst_i) enh <= 1'h0;
    else if (wr_ok && paddr_i == `ADC_CTRL_OFS) enh <= pwdata_i[`CTRL_ENH_BIT];
  end

  // Length of the current busy stretch
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) run <= 0;
    else run <= run + 1;
  end

  property p_pwr;
    wr_ok && paddr_i == `ADC_CTRL_OFS |=> conv_power_down_o == $past(pwdata_i[`CTRL_PD_BIT]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down not loaded");
  property p_nostart;
    $rose(busy_o) |-> !$past(conv_power_down_o);
  endproperty
  a_nostart: assert property (p_nostart) else $error("started while powered down");
  property p_sample;
    $rose(busy_o) |-> !conv_start_o [*3] ##1 conv_start_o;
  endproperty
  a_sample: assert property (p_sample) else $error("sample phase not three cycles");
  property p_len;
    $fell(busy_o) |-> run % (enh ? 20 : 16) == 0;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_prio;
    wr_ok && paddr_i == `ADC_PRIO_OFS |=> irq_prio_o == $past(pwdata_i[11:0]);
  endproperty
  a_prio: assert property (p_prio) else $error("priority not loaded");
  property p_premux;
    wr_ok && paddr_i == `ADC_PREMUX_OFS && !busy_o |->
      ##2 $past(busy_o) || premux_sel_o == $past(pwdata_i[7:0], 2);
  endproperty
  a_premux: assert property (p_premux) else $error("premux select not applied");
  property p_irq1;
    irq_o != 4'h0 |=> (irq_o & $past(irq_o)) == 4'h0;
  endproperty
  a_irq1: assert property (p_irq1) else $error("request pulse too long");
  property p_irqsrc;
    irq_o != 4'h0 |-> $past(busy_o);
  endproperty
  a_irqsrc: assert property (p_irqsrc) else $error("request without conversion");
  property p_force;
    wr_ok && paddr_i == `ADC_FORCE_OFS && !busy_o && !conv_power_down_o |-> ##[1:4] busy_o;
  endproperty
  a_force: assert property (p_force) else $error("forced trigger not run");
endmodule

bind adc_trigger_sequencer adc_seq_checker
  #(.NUM_TRIG(NUM_TRIG), .NUM_SLOTS(NUM_SLOTS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .conv_power_down_o(conv_power_down_o),
  .conv_start_o(conv_start_o), .premux_sel_o(premux_sel_o), .irq_o(irq_o),
  .irq_prio_o(irq_prio_o), .busy_o(busy_o));

// >>> adc_trigger_sequencer_test.sv
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module adc_trigger_sequencer_test;
  localparam int LIMIT = 40000;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        psel_i = 1'h0;
  logic        penable_i = 1'h0;
  logic        pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] trig_i = 32'h0;
  logic [11:0] conv_data_i, irq_prio_o;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, conv_power_down_o, conv_sample_o, conv_start_o;
  logic        fe_hold_o, busy_o;
  logic [3:0]  conv_channel_o, irq_o;
  logic [7:0]  premux_sel_o;
  logic [7:0]  ssel [24];
  logic [3:0]  schn [24];
  logic [1:0]  slin [24];
  logic        sien [24];
  int          miscompares = 0, n_tests = 0, cyc = 0, starts = 0, bl = 0, smp = 0;
  int          irqs [4] = '{default: 0};

  adc_trigger_sequencer u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .trig_i(trig_i), .conv_data_i(conv_data_i),
    .conv_power_down_o(conv_power_down_o), .conv_sample_o(conv_sample_o),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
    .premux_sel_o(premux_sel_o), .fe_hold_o(fe_hold_o), .irq_o(irq_o),
    .irq_prio_o(irq_prio_o), .busy_o(busy_o));
  afe_model u_afe (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o),
                   .channel_i(conv_channel_o), .sel_i(premux_sel_o), .data_o(conv_data_i));

  // Clock
  always #12.5 clk_i = ~clk_i;

  // Count starts, busy cycles and request pulses; cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (conv_start_o === 1'h1) starts++;
    if (busy_o === 1'h1) bl++;
    if (conv_sample_o === 1'h1 || conv_start_o === 1'h1) smp++;
    for (int l = 0; l < 4; l++) if (irq_o[l] === 1'h1) irqs[l]++;
    if (cyc == LIMIT) begin
      miscompares++;
      complete_run;
    end
  end

  task automatic complete_run;
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    @(posedge clk_i);
    while (pready_o !== 1'h1) @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask

  // Wait out a run and its trailing request pulse
  task automatic settle;
    repeat (8) @(posedge clk_i);
    while (busy_o !== 1'h0) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask

  // Run one chain by force or trigger edge and compare with the slot table
  task automatic chain(input int t, input int f, input int n, input int m, input int per);
    int ln, k, s, runs, st, b0, s0;
    int ex [4];
    logic [31:0] e;
    ln = $urandom % 4;
    runs = (m == 3) ? 2 : 1;
    e = (m == 0) ? 0 : m << (2 * (t % 16));
    wr(`ADC_EDGE_LO_OFS, (t < 16) ? e : 32'h0);
    wr(`ADC_EDGE_HI_OFS, (t < 16) ? 32'h0 : e);
    wr(`ADC_TRIG_CFG_BASE + 12'(4 * t), 32'(ln << 12 | 1 << 11 | (n - 1) << 5 | f));
    ex = irqs;
    for (k = 0; k < n; k++) begin
      s = (f + k) % 24;
      if (sien[s] && !(k == n - 1 && slin[s] == ln)) ex[slin[s]] += runs;
    end
    ex[ln] += runs;
    st = starts;
    b0 = bl;
    s0 = smp;
    if (m == 0) begin
      wr(`ADC_FORCE_OFS, 32'(t));
      wr(`ADC_FORCE_OFS, 32'(t));
    end else begin
      trig_i[t] <= 1'h1;
      settle;
      trig_i[t] <= 1'h0;
    end
    settle;
    check(starts - st, n * runs);
    check(bl - b0, per * n * runs);
    check(smp - s0, 3 * n * runs);
    for (k = 0; k < 4; k++) check(irqs[k], ex[k]);
    for (k = 0; k < n; k++) begin
      s = (f + k) % 24;
      rchk(`ADC_RESULT_BASE + 12'(4 * s), {20'h0, ssel[s], schn[s]}, 1'h0);
    end
  endtask

  initial begin
    logic [31:0] v;
    logic e;
    int i, c, st;
    int ex [4];
    v = $urandom(32'hf84cb092);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rchk(`ADC_CTRL_OFS, 32'h1, 1'h0);
    rchk(12'h01c, 32'h0, 1'h1);
    v = $urandom & 32'hfff;
    wr(`ADC_PRIO_OFS, v);
    check({20'h0, irq_prio_o}, v);
    wr(`ADC_PREMUX_OFS, 32'h1a5);
    // Link outputs are registered one edge behind the register
    @(posedge clk_i);
    check({23'h0, fe_hold_o, premux_sel_o}, 32'h1a5);
    wr(`ADC_CTRL_OFS, 32'h0);
    for (i = 0; i < 24; i++) begin
      v = $urandom;
      {slin[i], sien[i], ssel[i], schn[i]} = v[14:0];
      wr(`ADC_SLOT_CFG_BASE + 12'(4 * i), {17'h0, v[14:0]});
    end
    for (i = 0; i < 6; i++) begin
      chain($urandom % 32, i == 1 ? 23 : $urandom % 24, i == 0 ? 24 : 1 + $urandom % 24,
            i % 4, 16);
    end
    wr(`ADC_CTRL_OFS, 32'h2);
    chain(7, 22, 3, 1, 20);
    wr(`ADC_CTRL_OFS, 32'h0);
    // Repeating chain stopped by power-down, then a force while down
    st = starts;
    wr(`ADC_TRIG_CFG_BASE, 32'h420);
    wr(`ADC_FORCE_OFS, 32'h0);
    repeat (100) @(posedge clk_i);
    wr(`ADC_CTRL_OFS, 32'h1);
    settle;
    check(32'(starts - st > 2), 32'h1);
    st = starts;
    wr(`ADC_FORCE_OFS, 32'h0);
    settle;
    check(starts - st, 0);
    // Manual conversion with its request on line two
    c = $urandom % 16;
    ex = irqs;
    wr(`ADC_CTRL_OFS, 32'(c << 8 | 2 << 5 | 32'h18));
    settle;
    apb(1'h0, `ADC_STATUS_OFS, 32'h0, v, e);
    check(v[31:20], {8'ha5, c[3:0]});
    check(irqs[2], ex[2] + 1);
    // Manual repeat keeps converting until powered down
    st = starts;
    wr(`ADC_CTRL_OFS, 32'h0c);
    repeat (100) @(posedge clk_i);
    wr(`ADC_CTRL_OFS, 32'h1);
    settle;
    check(32'(starts - st > 2), 32'h1);
    complete_run;
  end
endmodule
